// File: inc/alc_defs.svh
// constants of the actuator loop control register bank
// assumes a 200 MHz core clock and an 8-bit register address from the serial front end
`ifndef ALC_DEFS_SVH
`define ALC_DEFS_SVH

// ****************************************************************
// register offsets and reset values
// ****************************************************************
`define ALC_ADDR_LOOP_ONE  8'h1B
`define ALC_ADDR_LOOP_TWO  8'h1C
`define ALC_ONE_RESET      8'h93
`define ALC_TWO_RESET      8'hD5

// ****************************************************************
// field positions
// ****************************************************************
`define ALC_ONE_BOOST_BIT  7
`define ALC_ONE_RSVD_BIT   6
`define ALC_ONE_BIAS_BIT   5
`define ALC_ONE_CODE_LSB   0
`define ALC_TWO_POL_BIT    7

// ****************************************************************
// timing, in microseconds and cycles
// ****************************************************************
`define ALC_CLK_MHZ        200
`define ALC_RES_STEP_US    100
`define ALC_RES_BASE_US    500
`define ALC_ROT_STEP_US    200
`define ALC_ROT_BASE_US    1000
`define ALC_ADJ_STEP_CYC   20

// ****************************************************************
// playback level
// ****************************************************************
`define ALC_LEVEL_MID      8'h80

`endif

// File: inc/alc_pkg.sv
// types of the actuator loop control register bank
// assumes alc_defs.svh carries every number
package alc_pkg;

  // ****************************************************************
  // register layouts
  // ****************************************************************
  typedef struct packed {
    logic       overdrive_gain_boost;
    logic       reserved;
    logic       common_mode_bias_enable;
    logic [4:0] drive_time_code;
  } alc_loop_one_t;

  typedef struct packed {
    logic       input_polarity_select;
    logic       brake_gain_reduce;
    logic [1:0] sample_period;
    logic [1:0] blank_period;
    logic [1:0] current_dissipate_period;
  } alc_loop_two_t;

  // ****************************************************************
  // playback interpretation and drive word
  // ****************************************************************
  typedef enum logic [1:0] {
    ALC_UNIDIR,
    ALC_BIDIR_OPEN,
    ALC_BIDIR_CLOSED
  } alc_interp_t;

  typedef struct packed {
    logic              brake;
    logic signed [9:0] amplitude;
  } alc_drive_t;

endpackage

// File: hdl/alc_drive_timer.sv
// drive period timer: loads a period from the drive-time code, then trims it for a resonant actuator only
// assumes reload, trim pulses and code come from logic on core_clk
`include "alc_defs.svh"

module alc_drive_timer
  import alc_pkg::*;
#(
  parameter int PW           = 22,
  parameter int RES_STEP_CYC = `ALC_RES_STEP_US * `ALC_CLK_MHZ,
  parameter int RES_BASE_CYC = `ALC_RES_BASE_US * `ALC_CLK_MHZ,
  parameter int ROT_STEP_CYC = `ALC_ROT_STEP_US * `ALC_CLK_MHZ,
  parameter int ROT_BASE_CYC = `ALC_ROT_BASE_US * `ALC_CLK_MHZ
)
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          resetn,
  // control
  input  wire logic          reload,
  input  wire logic          resonant_actuator,
  input  wire logic [4:0]    drive_time_code,
  input  wire logic          adj_up,
  input  wire logic          adj_dn,
  // timing out
  output logic               tick,
  output logic [PW-1:0]      period
);

  logic [PW-1:0] load_val;
  logic [PW-1:0] count;
  logic [PW-1:0] adj;
  logic [PW-1:0] floor_val;

  assign adj       = PW'(`ALC_ADJ_STEP_CYC);
  assign floor_val = PW'(RES_BASE_CYC);

  // ****************************************************************
  // period from code
  // ****************************************************************
  always_comb
  begin
    if (resonant_actuator)
      load_val = PW'(drive_time_code) * PW'(RES_STEP_CYC) + PW'(RES_BASE_CYC);
    else
      load_val = PW'(drive_time_code) * PW'(ROT_STEP_CYC) + PW'(ROT_BASE_CYC);
  end

  // code is only the first estimate; the loop trims toward resonance
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      period <= '0;
    else if (reload)
      period <= load_val;
    else if (resonant_actuator && adj_up && !adj_dn)
      period <= period + adj;
    else if (resonant_actuator && adj_dn && !adj_up && period >= floor_val + adj)
      period <= period - adj;
  end

  // a long period samples feedback slowly, a short one gives peaky output
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else if (reload || count <= PW'(1))
    begin
      count <= reload ? load_val : period;
      tick  <= !reload && period != '0;
    end
    else
    begin
      count <= count - PW'(1);
      tick  <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_res_period_load: assert property (@(posedge core_clk) disable iff (!resetn)
    reload && resonant_actuator |=>
      period == PW'($past(drive_time_code)) * PW'(RES_STEP_CYC) + PW'(RES_BASE_CYC))
    else $error("resonant period not code times step plus base");

  chk_rot_period_load: assert property (@(posedge core_clk) disable iff (!resetn)
    reload && !resonant_actuator |=>
      period == PW'($past(drive_time_code)) * PW'(ROT_STEP_CYC) + PW'(ROT_BASE_CYC))
    else $error("rotating-mass sample period not code times step plus base");

  chk_res_trim_up: assert property (@(posedge core_clk) disable iff (!resetn)
    !reload && resonant_actuator && adj_up && !adj_dn |=> period == $past(period) + adj)
    else $error("resonant period not trimmed upward");

  chk_rot_no_trim: assert property (@(posedge core_clk) disable iff (!resetn)
    !reload && !resonant_actuator |=> period == $past(period))
    else $error("rotating-mass period moved without reload");

endmodule

// File: hdl/alc_loop_ctrl.sv
// actuator loop control registers and the loop settings they steer
// assumes register port and loop inputs are driven by logic on core_clk
//
// Contract
// - boost bit 7 of loop_control_one, default 1, raises loop gain in overdrive
// - bias bit 5 drives 0.9 V bias onto trigger pin; default 0 leaves it off
// - resonant drive time is code times 0.1 ms plus 0.5 ms; code resets 0x13
// - resonant code is a starting estimate, trimmed live toward the optimum
// - rotating-mass sample period is code times 0.2 ms plus 1 ms
// - rotating-mass short period gives peaky output, long period slows loop
// - bit 7 of loop_control_two: 0 unidirectional, 1 bidirectional, default 1
// - unidirectional: brake from feedback only, sign bit becomes extra amplitude bit
// - unidirectional: output scales linearly, zero to full scale
// - bidirectional open loop: below half brakes, half is zero, above drives
`include "alc_defs.svh"

module alc_loop_ctrl
  import alc_pkg::*;
#(
  parameter int PW           = 22,
  parameter int RES_STEP_CYC = `ALC_RES_STEP_US * `ALC_CLK_MHZ,
  parameter int RES_BASE_CYC = `ALC_RES_BASE_US * `ALC_CLK_MHZ,
  parameter int ROT_STEP_CYC = `ALC_ROT_STEP_US * `ALC_CLK_MHZ,
  parameter int ROT_BASE_CYC = `ALC_ROT_BASE_US * `ALC_CLK_MHZ
)
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          resetn,
  // register port from the serial front end
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_rd,
  output logic [7:0]         reg_rdata,
  // loop state
  input  wire logic          resonant_actuator,
  input  wire logic          closed_loop,
  input  wire logic          overdrive_active,
  input  wire logic          feedback_brake_req,
  input  wire logic          period_adj_up,
  input  wire logic          period_adj_dn,
  input  wire logic [7:0]    play_level,
  // loop settings out
  output logic               loop_gain_boost,
  output logic               common_mode_bias_drive,
  output logic               drive_tick,
  output logic [PW-1:0]      drive_period,
  output alc_drive_t         drive,
  output alc_interp_t        interp,
  output logic               brake_gain_reduce,
  output logic [1:0]         sample_period,
  output logic [1:0]         blank_period,
  output logic [1:0]         current_dissipate_period
);

  alc_loop_one_t loop_control_one;
  alc_loop_two_t loop_control_two;
  alc_interp_t   next_interp;
  alc_drive_t    next_drive;
  logic          wr_one;
  logic          wr_two;
  logic          reload;
  logic          prev_resonant;
  logic          tick_int;
  logic [PW-1:0] period_int;
  logic [8:0]    level_off;

  assign wr_one = reg_wr && reg_addr == `ALC_ADDR_LOOP_ONE;
  assign wr_two = reg_wr && reg_addr == `ALC_ADDR_LOOP_TWO;

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      loop_control_one <= alc_loop_one_t'(`ALC_ONE_RESET);
    else if (wr_one)
    begin
      loop_control_one          <= alc_loop_one_t'(reg_wdata);
      loop_control_one.reserved <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      loop_control_two <= alc_loop_two_t'(`ALC_TWO_RESET);
    else if (wr_two)
      loop_control_two <= alc_loop_two_t'(reg_wdata);
  end

  // ****************************************************************
  // register reads, one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `ALC_ADDR_LOOP_ONE)
      begin
        reg_rdata                    <= loop_control_one;
        reg_rdata[`ALC_ONE_RSVD_BIT] <= 1'b0;
      end
      else if (reg_addr == `ALC_ADDR_LOOP_TWO)
        reg_rdata <= loop_control_two;
      else
        reg_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // static loop settings
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loop_gain_boost        <= 1'b0;
      common_mode_bias_drive <= 1'b0;
    end
    else
    begin
      loop_gain_boost        <= loop_control_one.overdrive_gain_boost && overdrive_active;
      // bias on a pwm or trigger input would corrupt it; software keeps it off there
      common_mode_bias_drive <= loop_control_one.common_mode_bias_enable;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      brake_gain_reduce        <= 1'b0;
      sample_period            <= 2'h0;
      blank_period             <= 2'h0;
      current_dissipate_period <= 2'h0;
    end
    else
    begin
      brake_gain_reduce        <= loop_control_two.brake_gain_reduce;
      sample_period            <= loop_control_two.sample_period;
      blank_period             <= loop_control_two.blank_period;
      current_dissipate_period <= loop_control_two.current_dissipate_period;
    end
  end

  // ****************************************************************
  // drive timer: reload on new code or actuator change
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reload        <= 1'b1;
      prev_resonant <= 1'b0;
    end
    else
    begin
      prev_resonant <= resonant_actuator;
      reload        <= wr_one || resonant_actuator != prev_resonant;
    end
  end

  alc_drive_timer #(
    .PW           (PW),
    .RES_STEP_CYC (RES_STEP_CYC),
    .RES_BASE_CYC (RES_BASE_CYC),
    .ROT_STEP_CYC (ROT_STEP_CYC),
    .ROT_BASE_CYC (ROT_BASE_CYC)
  ) u_timer (
    .core_clk          (core_clk),
    .resetn            (resetn),
    .reload            (reload),
    .resonant_actuator (resonant_actuator),
    .drive_time_code   (loop_control_one.drive_time_code),
    .adj_up            (period_adj_up),
    .adj_dn            (period_adj_dn),
    .tick              (tick_int),
    .period            (period_int)
  );

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive_tick   <= 1'b0;
      drive_period <= '0;
    end
    else
    begin
      drive_tick   <= tick_int;
      drive_period <= period_int;
    end
  end

  // ****************************************************************
  // playback interpretation
  // ****************************************************************
  always_comb
  begin
    if (!loop_control_two.input_polarity_select)
      next_interp = ALC_UNIDIR;
    else if (closed_loop)
      next_interp = ALC_BIDIR_CLOSED;
    else
      next_interp = ALC_BIDIR_OPEN;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      interp <= ALC_BIDIR_OPEN;
    else
      interp <= next_interp;
  end

  // level measured from mid scale, doubled so 100 % reaches 254, half the unidirectional 510
  assign level_off = {1'b0, play_level} - {1'b0, `ALC_LEVEL_MID};

  always_comb
  begin
    next_drive = '0;
    unique case (interp)
      ALC_UNIDIR:
      begin
        // no sign needed, so the whole level is magnitude
        next_drive.amplitude = {2'b00, play_level} <<< 1;
        next_drive.brake     = feedback_brake_req;
      end
      ALC_BIDIR_OPEN:
      begin
        next_drive.amplitude = 10'(signed'(level_off)) <<< 1;
        next_drive.brake     = play_level < `ALC_LEVEL_MID;
      end
      ALC_BIDIR_CLOSED:
      begin
        if (play_level > `ALC_LEVEL_MID)
          next_drive.amplitude = 10'(signed'(level_off)) <<< 1;
        next_drive.brake = feedback_brake_req;
      end
    endcase
  end

  // output moves only once per drive period
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      drive <= '0;
    else if (tick_int)
      drive <= next_drive;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_one_write(bit v, int b);
    reg_wr && reg_addr == `ALC_ADDR_LOOP_ONE && reg_wdata[b] == v;
  endsequence

  sequence s_one_read;
    reg_rd && !reg_wr && reg_addr == `ALC_ADDR_LOOP_ONE;
  endsequence

  chk_boost_gain_follow: assert property (@(posedge core_clk) disable iff (!resetn)
    s_one_write(1'b1, `ALC_ONE_BOOST_BIT) ##1 overdrive_active |=> loop_gain_boost)
    else $error("gain boost missing during overdrive");

  chk_boost_gain_off: assert property (@(posedge core_clk) disable iff (!resetn)
    !overdrive_active |=> !loop_gain_boost)
    else $error("gain boost outside overdrive");

  chk_bias_pin_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    s_one_write(1'b0, `ALC_ONE_BIAS_BIT) ##1 !wr_one |=> !common_mode_bias_drive)
    else $error("bias driven while enable clear");

  chk_bias_pin_on: assert property (@(posedge core_clk) disable iff (!resetn)
    s_one_write(1'b1, `ALC_ONE_BIAS_BIT) ##1 !wr_one |=> common_mode_bias_drive)
    else $error("bias not driven while enable set");

  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    s_one_read |=> reg_rdata[`ALC_ONE_RSVD_BIT] == 1'b0)
    else $error("reserved bit reads nonzero");

  chk_code_readback: assert property (@(posedge core_clk) disable iff (!resetn)
    s_one_write(1'b1, `ALC_ONE_CODE_LSB) ##1 s_one_read |=> reg_rdata[0])
    else $error("drive-time code did not read back");

  chk_polarity_select: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_wr && reg_addr == `ALC_ADDR_LOOP_TWO && !reg_wdata[`ALC_TWO_POL_BIT] ##1 !wr_two
      |=> interp == ALC_UNIDIR)
    else $error("unidirectional interpretation not selected");

  chk_unidir_scale: assert property (@(posedge core_clk) disable iff (!resetn)
    interp == ALC_UNIDIR && tick_int |=>
      drive.amplitude == ({2'b00, $past(play_level)} <<< 1))
    else $error("unidirectional amplitude not linear in level");

  chk_bidir_brake: assert property (@(posedge core_clk) disable iff (!resetn)
    interp == ALC_BIDIR_OPEN && tick_int |=>
      drive.brake == ($past(play_level) < `ALC_LEVEL_MID) &&
      (drive.amplitude < 0) == drive.brake)
    else $error("open-loop bidirectional brake wrong");

  chk_unidir_brake: assert property (@(posedge core_clk) disable iff (!resetn)
    interp == ALC_UNIDIR && tick_int |=> drive.brake == $past(feedback_brake_req))
    else $error("unidirectional brake not from feedback");

endmodule

// File: verification/alc_loop_ctrl_tb.sv
// self-checking bench for the actuator loop control register bank
// assumes the design's own assertions run alongside; the bench drives every port itself
`include "alc_defs.svh"

module alc_loop_ctrl_tb
  import alc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // small periods keep the run short; expectations use these values
  // ****************************************************************
  localparam int LS = 4;
  localparam int LB = 20;
  localparam int ES = 8;
  localparam int EB = 40;
  localparam int ADJ = `ALC_ADJ_STEP_CYC;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        core_clk           = 1'b0;
  logic        resetn             = 1'b0;
  logic [7:0]  reg_addr           = 8'h00;
  logic        reg_wr             = 1'b0;
  logic [7:0]  reg_wdata          = 8'h00;
  logic        reg_rd             = 1'b0;
  logic [7:0]  reg_rdata;
  logic        resonant_actuator  = 1'b1;
  logic        closed_loop        = 1'b0;
  logic        overdrive_active   = 1'b0;
  logic        feedback_brake_req = 1'b0;
  logic        period_adj_up      = 1'b0;
  logic        period_adj_dn      = 1'b0;
  logic [7:0]  play_level         = 8'h80;
  logic        loop_gain_boost;
  logic        common_mode_bias_drive;
  logic        drive_tick;
  logic [21:0] drive_period;
  alc_drive_t  drive;
  alc_interp_t interp;
  logic        brake_gain_reduce;
  logic [1:0]  sample_period;
  logic [1:0]  blank_period;
  logic [1:0]  current_dissipate_period;
  int          fail_count         = 0;
  int          checks             = 0;

  always #2.5 core_clk = ~core_clk;

  alc_loop_ctrl #(
    .PW           (22),
    .RES_STEP_CYC (LS),
    .RES_BASE_CYC (LB),
    .ROT_STEP_CYC (ES),
    .ROT_BASE_CYC (EB)
  ) dut_u (
    .core_clk                 (core_clk),
    .resetn                   (resetn),
    .reg_addr                 (reg_addr),
    .reg_wr                   (reg_wr),
    .reg_wdata                (reg_wdata),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .resonant_actuator        (resonant_actuator),
    .closed_loop              (closed_loop),
    .overdrive_active         (overdrive_active),
    .feedback_brake_req       (feedback_brake_req),
    .period_adj_up            (period_adj_up),
    .period_adj_dn            (period_adj_dn),
    .play_level               (play_level),
    .loop_gain_boost          (loop_gain_boost),
    .common_mode_bias_drive   (common_mode_bias_drive),
    .drive_tick               (drive_tick),
    .drive_period             (drive_period),
    .drive                    (drive),
    .interp                   (interp),
    .brake_gain_reduce        (brake_gain_reduce),
    .sample_period            (sample_period),
    .blank_period             (blank_period),
    .current_dissipate_period (current_dissipate_period)
  );

  // ****************************************************************
  // tasks: inputs always move 1 ns after the rising edge
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    step(1);
    reg_wr    = 1'b0;
  endtask

  // no idle edge first: a read straight after a write reaches the back-to-back case
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    reg_addr = a;
    reg_rd   = 1'b1;
    step(1);
    reg_rd   = 1'b0;
    step(1);
    check(name, reg_rdata, exp);
  endtask

  // bounded: a stuck tick timer ends the run instead of hanging it
  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      step(1);
      n++;
      if (n > 5000)
      begin
        fail_count++;
        results();
      end
    end
    while (drive_tick !== 1'b1);
  endtask

  task automatic per(input logic [7:0] one, input int exp);
    int n;
    wr(`ALC_ADDR_LOOP_ONE, one);
    step(4);
    check("drive_period", drive_period, exp);
    wait_tick(n);
    wait_tick(n);
    check("tick spacing", n, exp);
  endtask

  task automatic trim(input logic up, input logic dn, input int exp);
    period_adj_up = up;
    period_adj_dn = dn;
    step(1);
    period_adj_up = 1'b0;
    period_adj_dn = 1'b0;
    step(3);
    check("trimmed period", drive_period, exp);
  endtask

  // two ticks so the level is surely sampled by the second one
  task automatic play(input logic [7:0] lvl, input logic brq, input logic [10:0] exp);
    int n;
    play_level         = lvl;
    feedback_brake_req = brq;
    wait_tick(n);
    wait_tick(n);
    check("drive", drive, exp);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    step(4);
    check("interp in reset", interp, ALC_BIDIR_OPEN);
    resetn = 1'b1;
    step(2);
    rd(`ALC_ADDR_LOOP_ONE, `ALC_ONE_RESET, "loop_control_one");
    rd(`ALC_ADDR_LOOP_TWO, `ALC_TWO_RESET, "loop_control_two");
    rd(8'h1D, 8'h00, "unmapped read");
    check("interp", interp, ALC_BIDIR_OPEN);
    check("two fields", {brake_gain_reduce, sample_period, blank_period,
                         current_dissipate_period}, 7'h55);
    check("bias off", common_mode_bias_drive, 1'b0);
    overdrive_active = 1'b1;
    step(2);
    check("boost on", loop_gain_boost, 1'b1);
    wr(`ALC_ADDR_LOOP_ONE, 8'hFF);
    rd(`ALC_ADDR_LOOP_ONE, 8'hBF, "reserved bit");
    check("bias on", common_mode_bias_drive, 1'b1);
    wr(`ALC_ADDR_LOOP_ONE, 8'h40);
    rd(`ALC_ADDR_LOOP_ONE, 8'h00, "reserved only");
    check("bias cleared", common_mode_bias_drive, 1'b0);
    check("boost off", loop_gain_boost, 1'b0);
    overdrive_active = 1'b0;
    // drive time at both end codes and the reset code, both actuators
    per(8'h00, LB);
    per(8'h13, 8'h13 * LS + LB);
    per(8'h1F, 8'h1F * LS + LB);
    resonant_actuator = 1'b0;
    per(8'h00, EB);
    per(8'h13, 8'h13 * ES + EB);
    per(8'h1F, 8'h1F * ES + EB);
    // live trim: floor at base, both pulses ignored, none on rotating mass
    resonant_actuator = 1'b1;
    per(8'h00, LB);
    trim(1'b0, 1'b1, LB);
    trim(1'b1, 1'b0, LB + ADJ);
    trim(1'b1, 1'b1, LB + ADJ);
    trim(1'b0, 1'b1, LB);
    resonant_actuator = 1'b0;
    per(8'h00, EB);
    trim(1'b1, 1'b0, EB);
    // playback mapping, bidirectional open loop
    play(8'h00, 1'b0, 11'h700);
    play(8'h40, 1'b0, 11'h780);
    play(8'h80, 1'b1, 11'h000);
    play(8'hC0, 1'b1, 11'h080);
    // bidirectional closed loop: lower half gives no output
    closed_loop = 1'b1;
    step(2);
    check("interp closed", interp, ALC_BIDIR_CLOSED);
    play(8'h40, 1'b1, 11'h400);
    play(8'hC0, 1'b0, 11'h080);
    // unidirectional, selected by clearing bit 7 of loop_control_two whatever closed_loop is
    wr(`ALC_ADDR_LOOP_TWO, 8'h2A);
    rd(`ALC_ADDR_LOOP_TWO, 8'h2A, "loop_control_two write");
    check("interp unidir", interp, ALC_UNIDIR);
    check("two fields written", {brake_gain_reduce, sample_period, blank_period,
                                 current_dissipate_period}, 7'h2A);
    play(8'hFF, 1'b1, 11'h5FE);
    play(8'h80, 1'b0, 11'h100);
    play(8'h00, 1'b0, 11'h000);
    results();
  end
endmodule
